// [include/ism_pkg.sv]
// shared constants for the interrupt source mapping block
package ism_pkg;
   // identifier ranges of the controller inputs
   localparam int SHARED_BASE    = 32;   // first shared identifier
   localparam int SHARED_LAST    = 148;  // last shared identifier
   localparam int SHARED_COUNT   = SHARED_LAST - SHARED_BASE + 1;
   localparam int SHARED_SOURCES = 89;   // shared sources accepted
   localparam int PRIVATE_BASE   = 16;   // first private identifier
   localparam int PRIVATE_PER_CORE = 4;  // private sources per core
   localparam int TIMER_CHANNELS = 6;    // channels per six-channel timer
   localparam int USB_LINES      = 5;    // lines per usb controller
   localparam int POWER_LINES    = 4;    // power-management requests
   localparam int COMM_LINES     = 4;    // core communication requests

   // dedicated shared identifiers
   localparam int ID_DMA_FIRST_DONE   = 32;
   localparam int ID_DMA_FIRST_ABORT  = 33;
   localparam int ID_DMA_SECOND_DONE  = 34;
   localparam int ID_DMA_SECOND_ABORT = 35;
   localparam int ID_TIMER_A_FIRST    = 57;
   localparam int ID_TIMER_B_FIRST    = 63;
   localparam int ID_TIMER_B_LAST     = 68;
   localparam int ID_USB_OTG_FIRST    = 98;
   localparam int ID_USB_HOST_FIRST   = 103;
   localparam int ID_USB_HOST_LAST    = 107;
   localparam int ID_POWER_FIRST      = 115;
   localparam int ID_COMM_FIRST       = 123;
   localparam int ID_AXI_ERROR        = 127;
   localparam int ID_CPU_SLAVE_ERROR  = 142;
   localparam int ID_CPU_BUS_MONITOR  = 143;

   // private identifiers in use, order of the per-core port slice
   localparam int ID_PRIV_HYP_TIMER   = 26;
   localparam int ID_PRIV_VIRT_TIMER  = 27;
   localparam int ID_PRIV_SEC_TIMER   = 29;
   localparam int ID_PRIV_NSEC_TIMER  = 30;

   // reset levels of the synchronisers
   localparam logic SHARED_IDLE  = 1'h0;  // active-high shared inputs idle low
   localparam logic PRIVATE_IDLE = 1'h1;  // private inputs idle high

   typedef logic [SHARED_COUNT-1:0] ism_shared_t;

   // mark a span of identifiers in a shared-vector mask
   function automatic ism_shared_t ism_span(input int first,
                                            input int last);
      ism_shared_t m;
      m = '0;
      for (int i = first; i <= last; i++) begin
         m[i - SHARED_BASE] = 1'h1;
      end
      return m;
   endfunction : ism_span

   // identifiers that carry no source
   localparam ism_shared_t RESERVED_MASK =
      ism_span(36, 39) | ism_span(71, 71) | ism_span(79, 79) |
      ism_span(90, 91) | ism_span(119, 122) | ism_span(128, 141) |
      ism_span(147, 148);

   // identifiers driven by dedicated ports, not the generic vector
   localparam ism_shared_t DEDICATED_MASK =
      ism_span(ID_DMA_FIRST_DONE, ID_DMA_SECOND_ABORT) |
      ism_span(ID_TIMER_A_FIRST, ID_TIMER_B_LAST) |
      ism_span(ID_USB_OTG_FIRST, ID_USB_HOST_LAST) |
      ism_span(ID_POWER_FIRST, ID_POWER_FIRST + POWER_LINES - 1) |
      ism_span(ID_COMM_FIRST, ID_AXI_ERROR) |
      ism_span(ID_CPU_SLAVE_ERROR, ID_CPU_BUS_MONITOR);
endpackage : ism_pkg

// [rtl/ism_sync.sv]
// two-flop synchroniser for a bundle of level inputs
`timescale 1ns/100ps
module ism_sync #(
   parameter int   WIDTH    = 1,     // lines in the bundle
   parameter logic IDLE_VAL = 1'h0   // level held during reset
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] synced
);
   // both stages of the synchroniser, held as one record
   typedef struct packed {
      logic [WIDTH-1:0] meta;  // first stage, read only by second
      logic [WIDTH-1:0] hold;  // second stage, drives the output
   } ism_sync_st_t;

   ism_sync_st_t st_ff;   // registered stages
   ism_sync_st_t nxt_st;  // next value of the stages

   // shift one stage per clock; nothing but the hold stage reads meta
   always_comb begin
      nxt_st.meta = raw;
      nxt_st.hold = st_ff.meta;
   end

   // both stages reset to the idle level so nothing fires at start
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_ff <= '{meta: {WIDTH{IDLE_VAL}}, hold: {WIDTH{IDLE_VAL}}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // output taken straight from the second stage
   assign synced = st_ff.hold;
endmodule : ism_sync

// [rtl/ism_top.sv]
// interrupt source mapping and per-core request generation
`timescale 1ns/100ps
module ism_top #(
   parameter int NUM_CORES = 4,                   // processor cores
   parameter ism_pkg::ism_shared_t FAST_SEL = '0  // shared ids to fast
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic [ism_pkg::SHARED_COUNT-1:0] other_shared_irq,
   input  wire logic dma_first_done_irq,
   input  wire logic dma_first_abort_irq,
   input  wire logic dma_second_done_irq,
   input  wire logic dma_second_abort_irq,
   input  wire logic [ism_pkg::TIMER_CHANNELS-1:0] six_channel_timer_a,
   input  wire logic [ism_pkg::TIMER_CHANNELS-1:0] six_channel_timer_b,
   input  wire logic [ism_pkg::USB_LINES-1:0] usb_otg_irq,
   input  wire logic [ism_pkg::USB_LINES-1:0] usb_host_irq,
   input  wire logic cpu_slave_error_irq,
   input  wire logic cpu_bus_monitor_irq,
   input  wire logic [ism_pkg::POWER_LINES-1:0] power_mgmt_request_n,
   input  wire logic [ism_pkg::COMM_LINES-1:0] core_comm_request_n,
   input  wire logic axi_error_request_n,
   input  wire logic [NUM_CORES*ism_pkg::PRIVATE_PER_CORE-1:0]
                     core_timer_request_n,
   output logic      [NUM_CORES-1:0] core_normal_request_n,
   output logic      [NUM_CORES-1:0] core_fast_request_n
);
   localparam int PW = NUM_CORES * ism_pkg::PRIVATE_PER_CORE;
   localparam int HI_W = ism_pkg::SHARED_COUNT + 4
                       + 2 * ism_pkg::TIMER_CHANNELS
                       + 2 * ism_pkg::USB_LINES + 2;
   localparam int LO_W = ism_pkg::POWER_LINES + ism_pkg::COMM_LINES
                       + 1 + PW;

   // whole state: the registered requests, active low
   typedef struct packed {
      logic [NUM_CORES-1:0] normal_n;
      logic [NUM_CORES-1:0] fast_n;
   } ism_state_t;

   ism_state_t          st_ff;        // registered state
   ism_state_t          nxt_st;       // next state
   logic [HI_W-1:0]     hi_raw;       // active-high bundle from pins
   logic [HI_W-1:0]     hi_sync;      // same, synchronised
   logic [LO_W-1:0]     lo_raw;       // active-low bundle from pins
   logic [LO_W-1:0]     lo_sync;      // same, synchronised
   ism_pkg::ism_shared_t shared_lvl;  // mapped shared inputs
   logic [PW-1:0]       priv_act;     // private inputs, asserted high
   logic                any_normal;   // shared level on normal path
   logic                any_fast;     // shared level on fast path

   // pack the pins; sources live in other domains so sync first
   assign hi_raw = {other_shared_irq,
                    dma_first_done_irq, dma_first_abort_irq,
                    dma_second_done_irq, dma_second_abort_irq,
                    six_channel_timer_a, six_channel_timer_b,
                    usb_otg_irq, usb_host_irq,
                    cpu_slave_error_irq, cpu_bus_monitor_irq};
   assign lo_raw = {power_mgmt_request_n, core_comm_request_n,
                    axi_error_request_n, core_timer_request_n};

   // shared bundle idles low during reset
   ism_sync #(
      .WIDTH    (HI_W),
      .IDLE_VAL (ism_pkg::SHARED_IDLE)
   ) u_sync_hi (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .raw     (hi_raw),
      .synced  (hi_sync)
   );

   // active-low bundle idles high during reset
   ism_sync #(
      .WIDTH    (LO_W),
      .IDLE_VAL (ism_pkg::PRIVATE_IDLE)
   ) u_sync_lo (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .raw     (lo_raw),
      .synced  (lo_sync)
   );

   // fixed routing onto shared identifiers; pure wiring, no config
   always_comb begin
      int b;  // bit cursor into the synchronised bundles
      int k;  // shared identifier index
      b = 0;
      k = 0;
      shared_lvl = '0;
      // generic sources at their own identifier, level high
      shared_lvl = hi_sync[HI_W-1 -: ism_pkg::SHARED_COUNT]
                 & ~ism_pkg::DEDICATED_MASK;
      b = HI_W - ism_pkg::SHARED_COUNT - 1;
      // dma controllers at fixed identifiers
      shared_lvl[ism_pkg::ID_DMA_FIRST_DONE - ism_pkg::SHARED_BASE]
         = hi_sync[b];
      shared_lvl[ism_pkg::ID_DMA_FIRST_ABORT - ism_pkg::SHARED_BASE]
         = hi_sync[b-1];
      shared_lvl[ism_pkg::ID_DMA_SECOND_DONE - ism_pkg::SHARED_BASE]
         = hi_sync[b-2];
      shared_lvl[ism_pkg::ID_DMA_SECOND_ABORT - ism_pkg::SHARED_BASE]
         = hi_sync[b-3];
      b = b - 4;
      // timer channels, channel 0 at the lowest identifier
      for (int i = 0; i < ism_pkg::TIMER_CHANNELS; i++) begin
         k = ism_pkg::ID_TIMER_A_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = hi_sync[b - ism_pkg::TIMER_CHANNELS + 1 + i];
         k = ism_pkg::ID_TIMER_B_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = hi_sync[b - 2*ism_pkg::TIMER_CHANNELS + 1 + i];
      end
      b = b - 2 * ism_pkg::TIMER_CHANNELS;
      // usb lines, line 0 at the lowest identifier
      for (int i = 0; i < ism_pkg::USB_LINES; i++) begin
         k = ism_pkg::ID_USB_OTG_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = hi_sync[b - ism_pkg::USB_LINES + 1 + i];
         k = ism_pkg::ID_USB_HOST_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = hi_sync[b - 2*ism_pkg::USB_LINES + 1 + i];
      end
      b = b - 2 * ism_pkg::USB_LINES;
      shared_lvl[ism_pkg::ID_CPU_SLAVE_ERROR - ism_pkg::SHARED_BASE]
         = hi_sync[b];
      shared_lvl[ism_pkg::ID_CPU_BUS_MONITOR - ism_pkg::SHARED_BASE]
         = hi_sync[b-1];
      // active-low sources inverted to present high
      for (int i = 0; i < ism_pkg::POWER_LINES; i++) begin
         k = ism_pkg::ID_POWER_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = ~lo_sync[LO_W - ism_pkg::POWER_LINES + i];
      end
      for (int i = 0; i < ism_pkg::COMM_LINES; i++) begin
         k = ism_pkg::ID_COMM_FIRST - ism_pkg::SHARED_BASE + i;
         shared_lvl[k] = ~lo_sync[LO_W - ism_pkg::POWER_LINES
                                  - ism_pkg::COMM_LINES + i];
      end
      shared_lvl[ism_pkg::ID_AXI_ERROR - ism_pkg::SHARED_BASE]
         = ~lo_sync[PW];
      // reserved slots can never assert
      shared_lvl = shared_lvl & ~ism_pkg::RESERVED_MASK;
   end

   // private lines asserted while low; unused ids have no port
   assign priv_act = ~lo_sync[PW-1:0];

   // fast selection is a build-time choice, not a register
   assign any_fast   = |(shared_lvl & FAST_SEL);
   assign any_normal = |(shared_lvl & ~FAST_SEL);

   // one normal and one fast request per core, levels follow inputs
   always_comb begin
      nxt_st = st_ff;
      for (int c = 0; c < NUM_CORES; c++) begin
         // private sources of this core join its normal request
         nxt_st.normal_n[c] = ~(any_normal |
            (|priv_act[c*ism_pkg::PRIVATE_PER_CORE +:
                       ism_pkg::PRIVATE_PER_CORE]));
         nxt_st.fast_n[c] = ~any_fast;
      end
   end

   // register the state; requests idle high out of reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_ff <= '{normal_n: '1, fast_n: '1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign core_normal_request_n = st_ff.normal_n;
   assign core_fast_request_n   = st_ff.fast_n;
endmodule : ism_top

// [testbench/ism_top_assertions.sv]
// concurrent checks on the ports of the interrupt mapping top
`timescale 1ns/100ps
module ism_top_chk #(
   parameter int                   NUM_CORES = 4,   // cores served
   parameter ism_pkg::ism_shared_t FAST_SEL  = '0   // ids on fast line
) (
   input wire logic                           clk_sys,
   input wire logic                           rst_b,
   input wire logic                           dma_first_abort_irq,
   input wire logic                           dma_second_abort_irq,
   input wire logic [ism_pkg::USB_LINES-1:0]   usb_host_irq,
   input wire logic                           cpu_slave_error_irq,
   input wire logic [ism_pkg::POWER_LINES-1:0] power_mgmt_request_n,
   input wire logic [NUM_CORES*ism_pkg::PRIVATE_PER_CORE-1:0]
                                              core_timer_request_n,
   input wire logic [NUM_CORES-1:0]            core_normal_request_n,
   input wire logic [NUM_CORES-1:0]            core_fast_request_n
);
   logic all_nrm;   // every core sees a normal request
   logic all_fst;   // every core sees a fast request
   assign all_nrm = ~|core_normal_request_n;
   assign all_fst = ~|core_fast_request_n;

   // shared sources broadcast, so a lone source pulls every core
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_reset_idle: assert property (disable iff (1'h0)
      !rst_b |=> &core_normal_request_n && &core_fast_request_n)
      else $error("request active during reset");
   a_release_idle: assert property (
      $rose(rst_b) |-> ##1 (&core_normal_request_n && &core_fast_request_n))
      else $error("request active right after reset");
   a_first_abort: assert property (
      dma_first_abort_irq |=> ##2 (FAST_SEL[1] ? all_fst : all_nrm))
      else $error("first dma abort not routed");
   a_second_abort: assert property (
      dma_second_abort_irq |=> ##2 (FAST_SEL[3] ? all_fst : all_nrm))
      else $error("second dma abort not routed");
   a_host_disc: assert property (
      usb_host_irq[4] |=> ##2 (FAST_SEL[75] ? all_fst : all_nrm))
      else $error("host disconnect not routed");
   a_slave_err: assert property (
      cpu_slave_error_irq |=> ##2 (FAST_SEL[110] ? all_fst : all_nrm))
      else $error("slave error not routed");
   a_power_low: assert property (
      !power_mgmt_request_n[0] |=> ##2 (FAST_SEL[83] ? all_fst : all_nrm))
      else $error("power request not inverted");
   a_private_own: assert property (
      !core_timer_request_n[0] |=> ##2 !core_normal_request_n[0])
      else $error("private request not on own core");
endmodule : ism_top_chk

bind ism_top ism_top_chk #(.NUM_CORES(NUM_CORES), .FAST_SEL(FAST_SEL))
   u_chk (.clk_sys, .rst_b, .dma_first_abort_irq, .dma_second_abort_irq,
          .usb_host_irq, .cpu_slave_error_irq, .power_mgmt_request_n,
          .core_timer_request_n, .core_normal_request_n,
          .core_fast_request_n);

// [testbench/ism_core_model.sv]
// far-side model: processor cores latching the requests they take
`timescale 1ns/100ps
module ism_core_model #(
   parameter int NUM_CORES = 4   // cores listening
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic [NUM_CORES-1:0] core_normal_request_n,
   input  wire logic [NUM_CORES-1:0] core_fast_request_n,
   output logic      [NUM_CORES-1:0] normal_taken,
   output logic      [NUM_CORES-1:0] fast_taken
);
   // a core takes a request whenever its active-low line is low
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         normal_taken <= '0;
         fast_taken   <= '0;
      end else begin
         normal_taken <= normal_taken | ~core_normal_request_n;
         fast_taken   <= fast_taken | ~core_fast_request_n;
      end
   end
endmodule : ism_core_model

// [testbench/tb_irq_source_mapping.sv]
// self-checking bench for the interrupt source mapping block
`timescale 1ns/100ps
module tb_irq_source_mapping;
   localparam int NC = 2;     // cores, kept small for a short run
   localparam int W  = 162;   // packed stimulus width
   // fast set spans a dma, a reserved id, a generic, usb and cpu ids
   localparam ism_pkg::ism_shared_t FS = (117'h1 << 1) | (117'h1 << 4) |
      (117'h1 << 62) | (117'h1 << 75) | (117'h1 << 110);
   logic          clk_sys = 1'h0;
   logic          rst_b   = 1'h0;
   logic [W-1:0]  act     = '0;   // stimulus, all in active-high sense
   logic [W-1:0]  nxt;            // next random pattern
   logic [NC-1:0] nrm_n, fst_n, nrm_seen, fst_seen;
   logic [2*NC-1:0] h [3];        // expected outputs, three-stage lag
   logic [2*NC-1:0] seen_exp;     // expected sticky of taken requests
   logic          cmp_on  = 1'h0;
   int            bad_count   = 0;
   int            checks_done = 0;
   int            cyc         = 0;

   always #4 clk_sys = ~clk_sys;

   ism_top #(.NUM_CORES(NC), .FAST_SEL(FS)) dut (
      .clk_sys, .rst_b, .other_shared_irq(act[116:0]),
      .dma_first_done_irq(act[117]), .dma_first_abort_irq(act[118]),
      .dma_second_done_irq(act[119]), .dma_second_abort_irq(act[120]),
      .six_channel_timer_a(act[126:121]), .six_channel_timer_b(act[132:127]),
      .usb_otg_irq(act[137:133]), .usb_host_irq(act[142:138]),
      .cpu_slave_error_irq(act[143]), .cpu_bus_monitor_irq(act[144]),
      .power_mgmt_request_n(~act[148:145]),
      .core_comm_request_n(~act[152:149]), .axi_error_request_n(~act[153]),
      .core_timer_request_n(~act[161:154]),
      .core_normal_request_n(nrm_n), .core_fast_request_n(fst_n));

   ism_core_model #(.NUM_CORES(NC)) u_cores (
      .clk_sys, .rst_b, .core_normal_request_n(nrm_n),
      .core_fast_request_n(fst_n), .normal_taken(nrm_seen),
      .fast_taken(fst_seen));

   // reference mapping: returns {fast_n, normal_n} per core
   function automatic logic [2*NC-1:0] expect_req(logic [W-1:0] a);
      ism_pkg::ism_shared_t s;
      logic [2*NC-1:0]      r;
      s = a[116:0] & ~(ism_pkg::RESERVED_MASK | ism_pkg::DEDICATED_MASK);
      s[3:0] |= a[120:117];
      for (int n = 0; n < 6; n++) begin
         s[25+n] |= a[121+n];
         s[31+n] |= a[127+n];
      end
      for (int n = 0; n < 5; n++) begin
         s[66+n] |= a[133+n];
         s[71+n] |= a[138+n];
      end
      for (int n = 0; n < 4; n++) begin
         s[83+n] |= a[145+n];
         s[91+n] |= a[149+n];
      end
      s[95] |= a[153];
      s[111:110] |= a[144:143];
      for (int c = 0; c < NC; c++) begin
         r[c]    = (|(s & ~FS)) | (|a[154+4*c +: 4]);
         r[NC+c] = |(s & FS);
      end
      return ~r;
   endfunction : expect_req

   task automatic check(string what, logic [NC-1:0] got, logic [NC-1:0] ex);
      checks_done++;
      if (got !== ex) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // reference pipeline, sticky mirror and hang guard
   always @(posedge clk_sys) begin
      cyc    <= cyc + 1;
      cmp_on <= 1'h1;
      seen_exp <= rst_b ? (seen_exp | ~h[2]) : '0;
      if (!rst_b) begin
         for (int i = 0; i < 3; i++) h[i] <= '1;
      end else begin
         h[0] <= expect_req(act);
         h[1] <= h[0];
         h[2] <= h[1];
      end
      if (cyc > 6000) begin
         bad_count++;
         final_report();
      end
   end

   // outputs are settled mid-cycle
   always @(negedge clk_sys) begin
      if (cmp_on) begin
         check("normal", nrm_n, h[2][NC-1:0]);
         check("fast", fst_n, h[2][2*NC-1:NC]);
      end
   end

   initial begin
      void'($urandom(33052));
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'h1;
      // every line alone, reserved and dedicated generic bits included
      for (int i = 0; i < W; i++) begin
         @(posedge clk_sys) act <= {{(W-1){1'h0}}, 1'h1} << i;
         repeat (4) @(posedge clk_sys);
         act <= '0;
         repeat (3) @(posedge clk_sys);
      end
      // sparse random traffic, pulses down to one cycle, reset midway
      for (int k = 0; k < 600; k++) begin
         for (int b = 0; b < W; b++) nxt[b] = ($urandom % 48) == 0;
         act <= nxt;
         if (k == 300) rst_b <= 1'h0;
         if (k == 303) rst_b <= 1'h1;
         repeat (1 + $urandom % 4) @(posedge clk_sys);
      end
      act <= '0;
      repeat (6) @(posedge clk_sys);
      // sticky flags update on the edge, so look once they settle
      @(negedge clk_sys);
      check("normal taken", nrm_seen, seen_exp[NC-1:0]);
      check("fast taken", fst_seen, seen_exp[2*NC-1:NC]);
      final_report();
   end
endmodule : tb_irq_source_mapping
